// ### design/adc_converter_end.sv
`include "adc_link_defines.svh"

module adc_converter_end #(
   parameter int CONV_CYCLES          = `CONV_CYCLES,
   parameter int STATUS_TEST_DELAY_NS = `STATUS_TEST_DELAY_NS,
   parameter int EXT_OSC_PERIOD_NS    = `EXT_OSC_PERIOD_NS
) (
   // Clock, reset, enable
   input  logic                   CLK_SYS,
   input  logic                   RESETN,
   input  logic                   CE,
   // Link pins
   adc_link_if.device             LINK,
   // Oscillator choice and conversion data
   input  logic                   NOTCH_FREQUENCY_SELECT_EXT,
   input  logic [30:0]            CONV_RESULT,
   // Status
   output logic                   EOC_N,
   output adc_link_pkg::channel_t CONV_CHANNEL,
   output logic [7:0]             CHANNEL_SELECT,
   output logic                   MUX_OUTPUT_ENABLE
);
   import adc_link_pkg::*;

   // =================================================================
   // Timing counts
   localparam int TEST_INT_CYCLES =
      (STATUS_TEST_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int TEST_EXT_CYCLES =
      (`EXT_TEST_TENTHS * EXT_OSC_PERIOD_NS + 10 * `CLK_PERIOD_NS - 1)
      / (10 * `CLK_PERIOD_NS);

   dev_regs_t   r;
   dev_regs_t   next_r;
   logic [15:0] test_last;
   logic [7:0]  chan_dec;
   logic        cs_fall;
   logic        cs_rise;
   logic        msel_fall;
   logic        msel_rise;
   logic        mclk_rise;

   // =================================================================
   // Edges of synchronised pins
   assign cs_fall   = r.cs_d & ~r.cs_s2;
   assign cs_rise   = ~r.cs_d & r.cs_s2;
   assign msel_fall = r.msel_d & ~r.msel_s2;
   assign msel_rise = ~r.msel_d & r.msel_s2;
   assign mclk_rise = ~r.mclk_d & r.mclk_s2;

   // Status test length by oscillator source
   assign test_last = r.ext_s2 ? 16'(TEST_EXT_CYCLES - 1)
                               : 16'(TEST_INT_CYCLES - 1);

   // Channel decode
   for (genvar i = 0; i < `MUX_CHANNELS; i++) begin : g_dec
      assign chan_dec[i] = (r.mux_channel == 3'(i));
   end

   // =================================================================
   // Next state
   always_comb begin
      next_r = r;
      // Two-flop synchronisers and edge history
      next_r.cs_s1   = LINK.converter_select_n;
      next_r.cs_s2   = r.cs_s1;
      next_r.cs_d    = r.cs_s2;
      next_r.sck_s1  = LINK.sck;
      next_r.sck_s2  = r.sck_s1;
      next_r.msel_s1 = LINK.mux_select_n;
      next_r.msel_s2 = r.msel_s1;
      next_r.msel_d  = r.msel_s2;
      next_r.mclk_s1 = LINK.mux_clk;
      next_r.mclk_s2 = r.mclk_s1;
      next_r.mclk_d  = r.mclk_s2;
      next_r.din_s1  = LINK.din;
      next_r.din_s2  = r.din_s1;
      next_r.ext_s1  = NOTCH_FREQUENCY_SELECT_EXT;
      next_r.ext_s2  = r.ext_s1;

      // Multiplexer word shift while mux_select_n is high
      if (mclk_rise && r.msel_s2 && r.mux_bits != 3'(`MUX_WORD_BITS)) begin
         next_r.mux_sr   = {r.mux_sr[2:0], r.din_s2};
         next_r.mux_bits = r.mux_bits + 3'h1;
      end
      if (msel_rise) begin
         next_r.mux_sr     = 4'h0;
         next_r.mux_bits   = 3'h0;
         next_r.mux_out_en = 1'b0;
      end
      if (msel_fall) begin
         next_r.mux_out_en = 1'b1;
         if (r.mux_bits == 3'(`MUX_WORD_BITS) && r.mux_sr[3]) begin
            next_r.mux_channel = r.mux_sr[2:0];
         end
      end
      next_r.chan_onehot = chan_dec;

      // Conversion, status test and data output
      unique case (r.state)
         DEV_CONVERT: begin
            next_r.conv_cnt = r.conv_cnt + 24'h1;
            if (r.conv_cnt == 24'(CONV_CYCLES - 1)) begin
               next_r.state = DEV_SLEEP;
               next_r.eoc_n = 1'b0;
               next_r.shreg = {1'b0, CONV_RESULT};
               next_r.sdo_o = 1'b0;
               if (!r.cs_s2 && r.int_mode) begin
                  next_r.state    = DEV_TEST;
                  next_r.wait_cnt = 16'h0;
               end
            end
         end
         DEV_SLEEP: begin
            next_r.conv_cnt = 24'h0;
         end
         DEV_TEST: begin
            next_r.wait_cnt = r.wait_cnt + 16'h1;
            if (r.wait_cnt == test_last) begin
               next_r.state = DEV_SHIFT;
               next_r.sck_o = 1'b1;
               next_r.rises = 6'h1;
               next_r.half  = 4'h0;
            end
         end
         DEV_SHIFT: begin
            next_r.half = r.half + 4'h1;
            if (r.half == 4'(`SCK_HALF_CYCLES - 1)) begin
               next_r.half = 4'h0;
               if (r.sck_o && r.rises == 6'(`FRAME_RISES)) begin
                  next_r.state        = DEV_CONVERT;
                  next_r.conv_cnt     = 24'h0;
                  next_r.eoc_n        = 1'b1;
                  next_r.sdo_o        = 1'b1;
                  next_r.conv_channel = r.mux_channel;
               end else if (r.sck_o) begin
                  next_r.sck_o = 1'b0;
                  next_r.shreg = {r.shreg[30:0], 1'b0};
                  next_r.sdo_o = r.shreg[30];
               end else begin
                  next_r.sck_o = 1'b1;
                  next_r.rises = r.rises + 6'h1;
               end
            end
         end
      endcase

      // Select fall: choose clock mode, show status
      if (cs_fall) begin
         next_r.int_mode = r.sck_s2;
         next_r.sdo_oe_n = 1'b0;
         if (r.sck_s2) begin
            next_r.sck_oe_n = 1'b0;
            next_r.sck_o    = 1'b0;
            if (next_r.state == DEV_SLEEP) begin
               next_r.state    = DEV_TEST;
               next_r.wait_cnt = 16'h0;
            end
         end
      end

      // Pull-up follows the pin level
      if (r.guard != 2'h0) begin
         next_r.guard = r.guard - 2'h1;
      end
      if (!next_r.sck_oe_n) begin
         next_r.pullup_en = next_r.sck_o;
      end else if (!r.sck_s2 && r.guard == 2'h0) begin
         next_r.pullup_en = 1'b0;
      end

      // Select rise: release pins, abort test or frame
      if (cs_rise) begin
         next_r.sdo_oe_n = 1'b1;
         next_r.sck_oe_n = 1'b1;
         if (r.state == DEV_TEST) begin
            next_r.state     = DEV_SLEEP;
            next_r.sck_o     = 1'b0;
            next_r.pullup_en = 1'b1;
            next_r.guard     = 2'h3;
         end
         if (r.state == DEV_SHIFT) begin
            next_r.state        = DEV_CONVERT;
            next_r.conv_cnt     = 24'h0;
            next_r.eoc_n        = 1'b1;
            next_r.sdo_o        = 1'b1;
            next_r.conv_channel = next_r.mux_channel;
         end
      end
   end

   // =================================================================
   // State register
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         r <= DEV_RESET;
      end else if (CE) begin
         r <= next_r;
      end
   end

   // =================================================================
   // Outputs
   assign LINK.sck_o         = r.sck_o;
   assign LINK.sck_oe_n      = r.sck_oe_n;
   assign LINK.sck_pullup_en = r.pullup_en;
   assign LINK.sdo_o         = r.sdo_o;
   assign LINK.sdo_oe_n      = r.sdo_oe_n;
   assign EOC_N              = r.eoc_n;
   assign CONV_CHANNEL       = r.conv_channel;
   assign CHANNEL_SELECT     = r.chan_onehot;
   assign MUX_OUTPUT_ENABLE  = r.mux_out_en;

endmodule : adc_converter_end

// ### design/adc_host_end.sv
`include "adc_link_defines.svh"

module adc_host_end (
   // Clock, reset, enable
   input  logic        CLK_SYS,
   input  logic        RESETN,
   input  logic        CE,
   // Link pins
   adc_link_if.host    LINK,
   // AXI4-Lite write channels
   input  logic [7:0]  AWADDR,
   input  logic        AWVALID,
   output logic        AWREADY,
   input  logic [31:0] WDATA,
   input  logic [3:0]  WSTRB,
   input  logic        WVALID,
   output logic        WREADY,
   output logic [1:0]  BRESP,
   output logic        BVALID,
   input  logic        BREADY,
   // AXI4-Lite read channels
   input  logic [7:0]  ARADDR,
   input  logic        ARVALID,
   output logic        ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0]  RRESP,
   output logic        RVALID,
   input  logic        RREADY
);
   import adc_link_pkg::*;

   host_regs_t r;
   host_regs_t next_r;
   logic       sck_rise;

   assign sck_rise = r.sck_s2 & ~r.sck_d;

   // =================================================================
   // Next state
   always_comb begin
      logic start;
      start  = 1'b0;
      next_r = r;
      // Pin synchronisers
      next_r.sck_s1 = LINK.sck;
      next_r.sck_s2 = r.sck_s1;
      next_r.sck_d  = r.sck_s2;
      next_r.sdo_s1 = LINK.sdo;
      next_r.sdo_s2 = r.sdo_s1;

      // Write address and data taken in either order
      if (AWVALID && r.awready) begin
         next_r.aw_held = 1'b1;
         next_r.awaddr  = AWADDR;
      end
      if (WVALID && r.wready) begin
         next_r.w_held = 1'b1;
         next_r.wdata  = WDATA;
         next_r.wstrb  = WSTRB;
      end
      if (BREADY && r.bvalid) begin
         next_r.bvalid = 1'b0;
      end
      if (r.aw_held && r.w_held && !r.bvalid) begin
         next_r.aw_held = 1'b0;
         next_r.w_held  = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = `RESP_OKAY;
         if (r.awaddr == `REG_CTRL) begin
            if (r.wstrb[0]) begin
               next_r.prog = r.wdata[`CTRL_PROG];
               next_r.chan = r.wdata[`CTRL_CHAN_LSB +: 3];
               start       = r.wdata[`CTRL_START];
            end
         end else if (r.awaddr == `REG_STATUS) begin
            if (r.wstrb[0] && r.wdata[`STAT_DONE]) begin
               next_r.done = 1'b0;
            end
         end else if (r.awaddr != `REG_DATA) begin
            next_r.bresp = `RESP_SLVERR;
         end
      end
      next_r.awready = !next_r.aw_held && !next_r.bvalid;
      next_r.wready  = !next_r.w_held && !next_r.bvalid;

      // Read channel
      if (RREADY && r.rvalid) begin
         next_r.rvalid = 1'b0;
      end
      if (ARVALID && r.arready) begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = `RESP_OKAY;
         next_r.rdata  = 32'h0;
         if (ARADDR == `REG_CTRL) begin
            next_r.rdata[`CTRL_PROG]          = r.prog;
            next_r.rdata[`CTRL_CHAN_LSB +: 3] = r.chan;
         end else if (ARADDR == `REG_STATUS) begin
            next_r.rdata[`STAT_BUSY] = (r.state != HOST_IDLE);
            next_r.rdata[`STAT_DONE] = r.done;
            next_r.rdata[`STAT_EOC]  = r.eoc;
         end else if (ARADDR == `REG_DATA) begin
            next_r.rdata = {1'b0, r.data};
         end else begin
            next_r.rresp = `RESP_SLVERR;
         end
      end
      next_r.arready = !next_r.rvalid;

      // Frame sequencing
      unique case (r.state)
         HOST_IDLE: begin
            if (start) begin
               next_r.state  = HOST_FRAME;
               next_r.cs_n   = 1'b0;
               next_r.msel_n = 1'b1;
               next_r.rises  = 6'h0;
               next_r.word   = next_r.prog ? {1'b1, next_r.chan} : 4'h0;
               next_r.din    = next_r.prog;
            end
         end
         HOST_FRAME: begin
            if (sck_rise) begin
               next_r.rx    = {r.rx[30:0], r.sdo_s2};
               next_r.rises = r.rises + 6'h1;
               next_r.word  = {r.word[2:0], 1'b0};
               next_r.din   = r.word[2];
               if (r.rises == 6'(`FRAME_RISES - 1)) begin
                  next_r.state = HOST_CLOSE;
               end
            end
         end
         HOST_CLOSE: begin
            if (r.sck_s2) begin
               next_r.cs_n   = 1'b1;
               next_r.msel_n = 1'b0;
               next_r.state  = HOST_IDLE;
               next_r.data   = r.rx[30:0];
               next_r.eoc    = r.rx[31];
               next_r.done   = 1'b1;
            end
         end
      endcase
   end

   // =================================================================
   // State register
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         r <= HOST_RESET;
      end else if (CE) begin
         r <= next_r;
      end
   end

   // =================================================================
   // Outputs
   assign LINK.converter_select_n = r.cs_n;
   assign LINK.mux_select_n       = r.msel_n;
   assign LINK.din                = r.din;
   assign AWREADY                 = r.awready;
   assign WREADY                  = r.wready;
   assign BRESP                   = r.bresp;
   assign BVALID                  = r.bvalid;
   assign ARREADY                 = r.arready;
   assign RDATA                   = r.rdata;
   assign RRESP                   = r.rresp;
   assign RVALID                  = r.rvalid;

endmodule : adc_host_end

// ### design/adc_link_defines.svh
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH

// =====================================================================
// Timing
`define CLK_PERIOD_NS        4
`define SCK_HALF_CYCLES      8
`define FRAME_RISES          32
`define STATUS_TEST_DELAY_NS 23000
`define EXT_TEST_TENTHS      36
`define EXT_OSC_PERIOD_NS    10000
`define CONV_CYCLES          20000

// =====================================================================
// Multiplexer word
`define MUX_WORD_BITS        4
`define MUX_CHANNELS         8

// =====================================================================
// Host register offsets and fields
`define REG_CTRL             8'h00
`define REG_STATUS           8'h04
`define REG_DATA             8'h08
`define CTRL_START           0
`define CTRL_PROG            1
`define CTRL_CHAN_LSB        2
`define STAT_BUSY            0
`define STAT_DONE            1
`define STAT_EOC             2
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ### design/adc_link_if.sv
interface adc_link_if;
   // Host driven lines
   logic converter_select_n;
   logic mux_select_n;
   logic din;
   // Converter driven lines
   logic sck_o;
   logic sck_oe_n;
   logic sck_pullup_en;
   logic sdo_o;
   logic sdo_oe_n;
   // Optional outside driver on the clock pin
   logic ext_sck_o;
   logic ext_sck_oe_n;
   // Resolved wires
   logic sck;
   logic sdo;
   logic mux_clk;

   // Clock wire: converter driver first, then outside driver, then pull-up, otherwise stays low
   assign sck = !sck_oe_n ? sck_o : (!ext_sck_oe_n ? ext_sck_o : sck_pullup_en);
   // Data wire reads high when released
   assign sdo = !sdo_oe_n ? sdo_o : 1'b1;
   // Board routes the generated clock to the multiplexer clock
   assign mux_clk = sck;

   modport device (input converter_select_n, mux_select_n, din, sck, mux_clk,
                   output sck_o, sck_oe_n, sck_pullup_en, sdo_o, sdo_oe_n);
   modport host (output converter_select_n, mux_select_n, din,
                 input sck, sdo);
endinterface : adc_link_if

// ### design/adc_link_pkg.sv
`include "adc_link_defines.svh"

package adc_link_pkg;

   // ==================================================================
   // Types
   typedef logic [2:0] channel_t;

   typedef enum logic [1:0] {DEV_CONVERT, DEV_SLEEP, DEV_TEST, DEV_SHIFT} dev_state_t;
   typedef enum logic [1:0] {HOST_IDLE, HOST_FRAME, HOST_CLOSE} host_state_t;

   // Whole state of the converter end
   typedef struct packed {
      dev_state_t  state;
      logic        cs_s1, cs_s2, cs_d;
      logic        sck_s1, sck_s2;
      logic        msel_s1, msel_s2, msel_d;
      logic        mclk_s1, mclk_s2, mclk_d;
      logic        din_s1, din_s2;
      logic        ext_s1, ext_s2;
      logic        int_mode;
      logic        sck_o, sck_oe_n, pullup_en;
      logic [1:0]  guard;
      logic        sdo_o, sdo_oe_n, eoc_n;
      logic [31:0] shreg;
      logic [5:0]  rises;
      logic [3:0]  half;
      logic [15:0] wait_cnt;
      logic [23:0] conv_cnt;
      logic [3:0]  mux_sr;
      logic [2:0]  mux_bits;
      channel_t    mux_channel, conv_channel;
      logic [7:0]  chan_onehot;
      logic        mux_out_en;
   } dev_regs_t;

   // Whole state of the host end
   typedef struct packed {
      host_state_t state;
      logic        sck_s1, sck_s2, sck_d, sdo_s1, sdo_s2;
      logic        cs_n, msel_n, din;
      logic [3:0]  word;
      logic [5:0]  rises;
      logic [31:0] rx;
      logic [30:0] data;
      logic        eoc, done, prog;
      channel_t    chan;
      logic        awready, wready, aw_held, w_held, bvalid;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [1:0]  bresp, rresp;
      logic        arready, rvalid;
      logic [31:0] rdata;
   } host_regs_t;

   localparam dev_regs_t DEV_RESET = '{state: DEV_CONVERT, cs_s1: 1'b1, cs_s2: 1'b1,
      cs_d: 1'b1, sck_s1: 1'b1, sck_s2: 1'b1, sck_o: 1'b1, sck_oe_n: 1'b1,
      mclk_s1: 1'b1, mclk_s2: 1'b1, mclk_d: 1'b1,
      pullup_en: 1'b1, sdo_o: 1'b1, sdo_oe_n: 1'b1, eoc_n: 1'b1, default: '0};

   localparam host_regs_t HOST_RESET = '{state: HOST_IDLE, sck_s1: 1'b1, sck_s2: 1'b1,
      sck_d: 1'b1, cs_n: 1'b1, awready: 1'b1, wready: 1'b1, arready: 1'b1,
      default: '0};

endpackage : adc_link_pkg

// ### testbench/adc_internal_clock_serial_port_test.sv
`include "adc_link_defines.svh"

module adc_internal_clock_serial_port_test;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic        prog;
      logic [2:0]  ch;
      logic [30:0] res;
      logic        ext;
      logic [7:0]  sel;
      int          dly;
   } row_t;

   // Frames: program word, result, oscillator, expected one-hot and test delay
   row_t rows [9] = '{'{1'b1, 3'h5, 31'h12345678, 1'b0, 8'h20, 100},
      '{1'b1, 3'h0, 31'h7fffffff, 1'b0, 8'h01, 100}, '{1'b0, 3'h3, 31'h0, 1'b0, 8'h01, 100},
      '{1'b1, 3'h1, 31'h55555555, 1'b1, 8'h02, 180}, '{1'b1, 3'h2, 31'h2aaaaaaa, 1'b0, 8'h04, 100},
      '{1'b1, 3'h3, 31'h0000ffff, 1'b0, 8'h08, 100}, '{1'b1, 3'h4, 31'h7fff0000, 1'b0, 8'h10, 100},
      '{1'b1, 3'h6, 31'h00000001, 1'b0, 8'h40, 100}, '{1'b1, 3'h7, 31'h40000000, 1'b0, 8'h80, 100}};

   logic clk_sys = 1'b0, resetn = 1'b0, host_resetn = 1'b0, ext_osc = 1'b0, sck_q = 1'b1;
   logic ce = 1'b1, ext_drv = 1'b1, ext_drv_oe_n = 1'b1;
   logic [3:0]  wstrb = 4'hf;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, chan_sel;
   logic [31:0] wdata = 32'h0, rdata, d, s;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, eoc_n, mux_en, armed = 1'b1;
   logic [1:0]  bresp, rresp, r;
   logic [30:0] conv_result = 31'h12345678;
   adc_link_pkg::channel_t conv_ch;
   int n_fail = 0, n_checks = 0, cycles = 0, low_cnt = 0, delay = 0, n;

   // ==================================================================
   // Clock, link and the two ends
   always #2 clk_sys = ~clk_sys;

   adc_link_if adc_link_if_i ();
   assign adc_link_if_i.ext_sck_o = ext_drv;
   assign adc_link_if_i.ext_sck_oe_n = ext_drv_oe_n;

   adc_converter_end #(.CONV_CYCLES(200), .STATUS_TEST_DELAY_NS(400),
      .EXT_OSC_PERIOD_NS(200)) adc_converter_end_i (.CLK_SYS(clk_sys), .RESETN(resetn),
      .CE(ce), .LINK(adc_link_if_i.device), .NOTCH_FREQUENCY_SELECT_EXT(ext_osc),
      .CONV_RESULT(conv_result), .EOC_N(eoc_n), .CONV_CHANNEL(conv_ch),
      .CHANNEL_SELECT(chan_sel), .MUX_OUTPUT_ENABLE(mux_en));

   adc_host_end adc_host_end_i (.CLK_SYS(clk_sys), .RESETN(resetn && host_resetn), .CE(ce),
      .LINK(adc_link_if_i.host), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

   adc_link_props #(.TEST_CYCLES(100)) adc_link_props_i (.CLK_SYS(clk_sys),
      .RESETN(resetn), .converter_select_n(adc_link_if_i.converter_select_n),
      .mux_select_n(adc_link_if_i.mux_select_n), .sck_o(adc_link_if_i.sck_o),
      .sck_oe_n(adc_link_if_i.sck_oe_n), .sck_pullup_en(adc_link_if_i.sck_pullup_en),
      .sdo_oe_n(adc_link_if_i.sdo_oe_n), .ext_sck_oe_n(adc_link_if_i.ext_sck_oe_n),
      .sck(adc_link_if_i.sck), .sdo(adc_link_if_i.sdo));

   // ==================================================================
   // Timeout and delay from select fall to the first clock rise
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      sck_q <= adc_link_if_i.sck;
      if (adc_link_if_i.converter_select_n) begin
         low_cnt <= 0;
         armed <= 1'b1;
      end else begin
         low_cnt <= low_cnt + 1;
         if (armed && adc_link_if_i.sck && !sck_q) begin
            delay <= low_cnt;
            armed <= 1'b0;
         end
      end
      if (cycles == 40000) begin
         n_fail++;
         results();
      end
   end

   // ==================================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   // Whole frame: start, wait for done, fetch the result, clear done
   task automatic frame(input logic prog, input logic [2:0] ch, output logic [31:0] dv,
                        output logic [31:0] sv);
      logic [1:0] rs;
      axi_wr(`REG_CTRL, (32'(ch) << `CTRL_CHAN_LSB) | (32'(prog) << `CTRL_PROG) | 32'h1, rs);
      do axi_rd(`REG_STATUS, sv, rs); while (sv[`STAT_DONE] !== 1'b1 || sv[`STAT_BUSY] !== 1'b0);
      axi_rd(`REG_DATA, dv, rs);
      axi_wr(`REG_STATUS, 32'h2, rs);
   endtask : frame

   task automatic pulse_host();
      @(posedge clk_sys);
      host_resetn <= 1'b0;
      @(posedge clk_sys);
      host_resetn <= 1'b1;
   endtask : pulse_host

   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // ==================================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      host_resetn <= 1'b1;
      foreach (rows[i]) begin
         ext_osc <= rows[i].ext;
         while (eoc_n !== 1'b0) @(posedge clk_sys);
         frame(rows[i].prog, rows[i].ch, d, s);
         check(d[30:0], rows[i].res);
         check(s[`STAT_EOC], 1'b0);
         check(32'(delay >= rows[i].dly && delay <= rows[i].dly + 6), 32'h1);
         check(eoc_n, 1'b1);
         check(chan_sel, rows[i].sel);
         check(mux_en, 1'b1);
         check(32'h1 << conv_ch, rows[i].sel);
         if (i < 8) conv_result <= rows[i + 1].res;
      end
      // Status test cut short keeps sleep and the held result
      while (eoc_n !== 1'b0) @(posedge clk_sys);
      conv_result <= 31'h0abcdef0;
      axi_wr(`REG_CTRL, 32'h1, r);
      repeat (30) @(posedge clk_sys);
      pulse_host();
      repeat (12) @(posedge clk_sys);
      check(eoc_n, 1'b0);
      check(adc_link_if_i.sck, 1'b1);
      frame(1'b0, 3'h0, d, s);
      check(d[30:0], rows[8].res);
      // Select rise in mid-frame aborts and starts a conversion
      while (eoc_n !== 1'b0) @(posedge clk_sys);
      axi_wr(`REG_CTRL, 32'h1, r);
      @(posedge adc_link_if_i.sck);
      repeat (2) @(posedge clk_sys);
      pulse_host();
      repeat (8) @(posedge clk_sys);
      check(eoc_n, 1'b1);
      for (n = 0; n < 400 && eoc_n !== 1'b0; n++) @(posedge clk_sys);
      check(32'(n >= 180 && n <= 215), 32'h1);
      // Outside driver pulls the clock low, then lets go: it stays low
      ext_drv <= 1'b0;
      ext_drv_oe_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      ext_drv_oe_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      check(adc_link_if_i.sck, 1'b0);
      // Second reset, then register refusals
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      check(eoc_n, 1'b1);
      check(adc_link_if_i.sdo_oe_n, 1'b1);
      axi_rd(`REG_STATUS, s, r);
      check(s, 32'h0);
      axi_rd(8'h0c, s, r);
      check(r, `RESP_SLVERR);
      axi_wr(8'h10, 32'h1, r);
      check(r, `RESP_SLVERR);
      // Control write with no byte lane enabled starts nothing
      wstrb <= 4'h0;
      axi_wr(`REG_CTRL, 32'h1, r);
      wstrb <= 4'hf;
      axi_rd(`REG_STATUS, s, r);
      check(s[`STAT_BUSY], 1'b0);
      // Enable low freezes the conversion count
      ce <= 1'b0;
      repeat (250) @(posedge clk_sys);
      check(eoc_n, 1'b1);
      ce <= 1'b1;
      for (n = 0; n < 400 && eoc_n !== 1'b0; n++) @(posedge clk_sys);
      check(32'(n > 0 && n < 200), 32'h1);
      results();
   end
endmodule : adc_internal_clock_serial_port_test

// ### testbench/adc_link_props.sv
module adc_link_props #(
   parameter int TEST_CYCLES = 100
) (
   // Clock and reset
   input logic CLK_SYS,
   input logic RESETN,
   // Link lines
   input logic converter_select_n,
   input logic mux_select_n,
   input logic sck_o,
   input logic sck_oe_n,
   input logic sck_pullup_en,
   input logic sdo_oe_n,
   input logic ext_sck_oe_n,
   input logic sck,
   input logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] low_cnt;
   logic [5:0]  rises;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   // ==================================================================
   // Frame position: cycles with select low, converter driven rises
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN || converter_select_n) begin
         low_cnt <= 16'h0000;
         rises   <= 6'h00;
      end else begin
         low_cnt <= low_cnt + 16'h0001;
         if ($rose(sck) && !sck_oe_n) begin
            rises <= rises + 6'h01;
         end
      end
   end

   // ==================================================================
   // Assertions
   chk_sdo_released: assert property (converter_select_n [*6] |-> sdo_oe_n && sck_oe_n)
      else $error("link pins driven while deselected");
   chk_select_low: assert property ($fell(converter_select_n) && sck |->
      ##[1:5] (!sck_oe_n && !sck_o && !sdo_oe_n))
      else $error("clock and flag not driven after select fall");
   chk_test_delay: assert property ($rose(sck) && !sck_oe_n && rises == 6'h00 |->
      low_cnt >= 16'(TEST_CYCLES))
      else $error("first clock rise too early");
   chk_half_period: assert property ($fell(sck) && !$past(sck_oe_n) |->
      (!sck) [*8] ##1 sck)
      else $error("clock low phase not eight cycles");
   chk_frame_end: assert property ($rose(sck) && !sck_oe_n && rises == 6'h1f |->
      sck [*8] ##1 (sck && sdo) [*4])
      else $error("frame end not idle high");
   chk_mux_inverse: assert property (mux_select_n == !converter_select_n)
      else $error("mux select not inverse of select");
   chk_release_high: assert property ($rose(converter_select_n) |->
      ##[1:10] (sck_oe_n && sck))
      else $error("clock not released high after select rise");
   chk_pullup_off: assert property ($fell(sck) |-> ##[0:3] !sck_pullup_en)
      else $error("pull-up left on with clock low");
   chk_pullup_at_fall: assert property ($fell(converter_select_n) && ext_sck_oe_n |->
      sck_pullup_en)
      else $error("pull-up off at select fall");
   chk_sdo_steady: assert property ($rose(sck) && !sck_oe_n && !$past(sck_oe_n) |->
      $stable(sdo))
      else $error("data changed on clock rise");

   // Main scenarios
   cover property ($rose(sck) && rises == 6'h1f);
   cover property ($rose(converter_select_n) && !sck);
   cover property ($rose(converter_select_n) && rises != 6'h00 && rises != 6'h20);
endmodule : adc_link_props
